// >>> dv/adcavg_core_model.sv
// sampling core stand-in: answers each start pulse with one sample
// assumes starts come one at a time, as the sequencer issues them
`timescale 1ns/10ps
`default_nettype none

module adcavg_core_model (
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic start_i, // start pulse from the sequencer
  input wire logic [3:0] dly_i, // answer delay in cycles, 1 or more
  input wire logic [adcavg_pkg::ADCAVG_RES_W-1:0] smp_i,
  output logic valid_o,
  output logic [adcavg_pkg::ADCAVG_RES_W-1:0] data_o
);
  logic [3:0] cnt_r; // cycles left until the answer
  // data toggles outside the valid cycle, so a late read shows up
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      cnt_r <= 4'h0;
      valid_o <= 1'b0;
      data_o <= '0;
    end else begin
      valid_o <= (cnt_r == 4'h1);
      data_o <= (cnt_r == 4'h1) ? smp_i : ~data_o;
      cnt_r <= start_i ? dly_i : (cnt_r != 4'h0) ? cnt_r - 4'h1 : 4'h0;
    end
  end
endmodule
`default_nettype wire

// >>> dv/tb.sv
// self-checking bench for the averaging sequencer
// assumes the core stand-in answers every conversion start
`timescale 1ns/10ps
`default_nettype none

module tb;
  import adcavg_pkg::*;
  // ****
  // rows: trigger kind, log2 count, shift, sample, expected value
  // ****
  typedef struct packed {
    logic evt;
    logic [3:0] lg;
    logic rs;
    logic [11:0] smp;
    logic [19:0] exp;
  } adcavg_row_t;
  // last row fills the accumulator top bit, so shift must not sign fill
  localparam adcavg_row_t ROWS [4] = '{
    '{1'b0, 4'h0, 1'b0, 12'h123, 20'h00123},
    '{1'b0, 4'h3, 1'b0, 12'hfff, 20'h07ff8},
    '{1'b1, 4'h2, 1'b1, 12'h9a5, 20'h009a5},
    '{1'b0, 4'h8, 1'b1, 12'h800, 20'h00800}
  };
  logic clock_i = 1'b0, rst_b_i = 1'b0, start = 1'b0, evt = 1'b0;
  logic evt_sel = 1'b0, flag_clr = 1'b0, busy, cstart, cvalid, done;
  logic scan_chk = 1'b0;
  adcavg_cfg_t cfg = '0;
  adcavg_res_t res;
  logic [ADCAVG_RES_W-1:0] cdata, smp = '0;
  logic [3:0] ofs;
  int fails = 0, total_checks = 0, nst = 0, cyc = 0, k = 0;

  initial forever #2 clock_i = ~clock_i;

  adcavg_seq i_dut (.CLOCK_I(clock_i), .RST_B_I(rst_b_i), .CFG_I(cfg),
    .START_I(start), .EVENT_I(evt), .EVENT_SEL_I(evt_sel),
    .FLAG_CLR_I(flag_clr), .START_BUSY_O(busy), .CONV_START_O(cstart),
    .CONV_VALID_I(cvalid), .CONV_DATA_I(cdata), .INPUT_OFS_O(ofs),
    .RESULT_O(res), .DONE_FLAG_O(done));
  adcavg_core_model i_core (.clk_i(clock_i), .rst_b_i(rst_b_i),
    .start_i(cstart), .dly_i(4'h2), .smp_i(smp), .valid_o(cvalid),
    .data_o(cdata));

  task automatic results;
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  task automatic chk(input logic ok, input string msg);
    total_checks++;
    if (ok !== 1'b1) begin
      fails++;
      $display("MISMATCH %0t %s", $time, msg);
    end
  endtask

  // one-cycle trigger, by start bit or by event
  task automatic trig(input logic e);
    @(negedge clock_i);
    start = !e;
    evt = e;
    @(negedge clock_i);
    start = 1'b0;
    evt = 1'b0;
  endtask

  // bounded wait on the flag (sel=1) or on busy falling (sel=0)
  task automatic wait_for(input logic sel);
    int n;
    n = 0;
    while ((sel ? done !== 1'b1 : busy !== 1'b0) && n < 3000) begin
      @(negedge clock_i);
      n++;
    end
    chk(sel ? done === 1'b1 : busy === 1'b0, "sequence never ended");
    @(negedge clock_i);
    flag_clr = 1'b1;
    @(negedge clock_i);
    flag_clr = 1'b0;
  endtask

  // counts starts, checks the offset each scan start uses; cuts hangs short
  always @(posedge clock_i) begin
    cyc++;
    if (cstart === 1'b1) begin
      if (scan_chk)
        chk(ofs === 4'(nst >> cfg.avg_log), "offset moved early");
      nst++;
    end
    if (cyc == 20000) begin
      fails++;
      results;
    end
  end

  initial begin
    repeat (6) @(negedge clock_i);
    chk(done === 1'b0 && cstart === 1'b0 && res === '0 && busy === 1'b0 &&
        ofs === 4'h0, "reset values");
    rst_b_i = 1'b1;
    cfg.enable = 1'b1;
    evt_sel = 1'b1;
    foreach (ROWS[i]) begin
      cfg.avg_log = ROWS[i].lg;
      cfg.right_shift = ROWS[i].rs;
      smp = ROWS[i].smp;
      nst = 0;
      trig(ROWS[i].evt);
      wait_for(1'b1);
      chk(nst == (1 << ROWS[i].lg), "conversion count");
      chk(res.value === ROWS[i].exp, "averaged value");
    end
    // scan over three inputs, two samples each
    cfg.scan_en = 1'b1;
    cfg.scan_last = 4'h2;
    cfg.avg_log = 4'h1;
    nst = 0;
    scan_chk = 1'b1;
    trig(1'b0);
    wait_for(1'b0);
    chk(nst == 6, "scan conversion count");
    chk(res === {20'h00800, 4'h2}, "scan result");
    scan_chk = 1'b0;
    // free running, stopped in mid-average
    cfg.scan_en = 1'b0;
    cfg.avg_log = 4'h3;
    cfg.free_run = 1'b1;
    repeat (12) @(negedge clock_i);
    cfg.free_run = 1'b0;
    @(negedge clock_i);
    chk(busy === 1'b0, "free run kept busy");
    k = nst;
    repeat (10) @(negedge clock_i);
    chk(nst == k, "free run kept converting");
    // disable and enable, then a clean two-sample sum (the trigger clears the partial sum)
    cfg.enable = 1'b0;
    @(negedge clock_i);
    cfg.enable = 1'b1;
    cfg.avg_log = 4'h1;
    cfg.right_shift = 1'b0;
    smp = 12'h00f;
    trig(1'b0);
    wait_for(1'b1);
    chk(res.value === 20'h0001e, "stale partial sum");
    // signed set: here the shift must copy the sign bit down
    cfg.signed_mode = 1'b1;
    cfg.avg_log = 4'h2;
    cfg.right_shift = 1'b1;
    smp = 12'h800;
    trig(1'b0);
    wait_for(1'b1);
    chk(res.value === 20'hff800, "signed average");
    // an event that is not selected must not launch anything
    evt_sel = 1'b0;
    k = nst;
    trig(1'b1);
    repeat (4) @(negedge clock_i);
    chk(busy === 1'b0 && nst == k, "unselected event ran");
    // reset in mid-set, then a clean set after it
    trig(1'b0);
    repeat (3) @(negedge clock_i);
    rst_b_i = 1'b0;
    @(negedge clock_i);
    chk(busy === 1'b0 && done === 1'b0 && res === '0, "mid-run reset");
    rst_b_i = 1'b1;
    trig(1'b0);
    wait_for(1'b1);
    chk(res.value === 20'hff800, "average after reset");
    results;
  end
endmodule
`default_nettype wire

// >>> logic/adcavg_pkg.sv
// package for the conversion averaging sequencer: constants and carriers
// assumes a single 250 MHz clock domain and no software bus
`default_nettype none

package adcavg_pkg;

  // ********************************************************************
  // widths and reset values
  // ********************************************************************
  localparam int ADCAVG_RES_W = 12; // raw conversion width
  localparam int ADCAVG_ACC_W = 20; // accumulator width, up to 256 samples
  localparam int ADCAVG_CNT_W = 9; // sample counter width
  localparam int ADCAVG_LOG_W = 4; // log2 of sample count field
  localparam int ADCAVG_MAX_LOG = 8; // largest log2 sample count
  localparam logic [ADCAVG_ACC_W-1:0] ADCAVG_ACC_RST = 20'h00000;
  localparam logic [ADCAVG_CNT_W-1:0] ADCAVG_CNT_RST = 9'h000;
  localparam logic [3:0] ADCAVG_INP_RST = 4'h0; // scan offset after reset

  // ********************************************************************
  // carriers
  // ********************************************************************
  // configuration from software control bits
  typedef struct packed {
    logic enable; // converter enable
    logic free_run; // free-running mode
    logic scan_en; // channel-scan mode
    logic [3:0] scan_last; // last scan offset
    logic [ADCAVG_LOG_W-1:0] avg_log; // log2 of samples to average
    logic right_shift; // divide result by sample count
    logic signed_mode; // signed conversions
  } adcavg_cfg_t;

  // result word towards software
  typedef struct packed {
    logic [ADCAVG_ACC_W-1:0] value; // averaged or accumulated value
    logic [3:0] input_ofs; // scan offset that produced it
  } adcavg_res_t;

  // sequencer states, gray along idle-convert-wait-finish
  typedef enum logic [1:0] {
    ADCAVG_IDLE = 2'b00,
    ADCAVG_CONV = 2'b01,
    ADCAVG_WAIT = 2'b11,
    ADCAVG_DONE = 2'b10
  } adcavg_state_t;

endpackage

`default_nettype wire

// >>> logic/adcavg_seq.sv
// averaging sequencer: one trigger runs N conversions and the average
// assumes the sampling core answers each start with one data-valid pulse
//
// Behaviour
// - one trigger launches all N conversions
// - set done flag after Nth conversion
// - scan advances only after full averaging
// - one event completes whole averaging sequence
// - unsigned shifted result upper bits are zero
// - clearing free-run stops averaging at once
`timescale 1ns/10ps
`default_nettype none

module adcavg_seq (
  input wire logic CLOCK_I,
  input wire logic RST_B_I,
  input wire adcavg_pkg::adcavg_cfg_t CFG_I, // software control bits
  input wire logic START_I, // software start bit, one-cycle pulse
  input wire logic EVENT_I, // event trigger, one-cycle pulse
  input wire logic EVENT_SEL_I, // accept event triggers
  input wire logic FLAG_CLR_I, // software clears done flag
  output logic START_BUSY_O, // start bit reads set while busy
  output logic CONV_START_O, // start pulse to sampling core
  input wire logic CONV_VALID_I, // sample ready from sampling core
  input wire logic [adcavg_pkg::ADCAVG_RES_W-1:0] CONV_DATA_I,
  output logic [3:0] INPUT_OFS_O, // input offset selected now
  output adcavg_pkg::adcavg_res_t RESULT_O, // latched result
  output logic DONE_FLAG_O // end-of-averaging flag
);
  import adcavg_pkg::*;

  // ********************************************************************
  // state
  // ********************************************************************
  adcavg_state_t state_r; // sequencer state
  logic [ADCAVG_ACC_W-1:0] acc_r; // running sum
  logic [ADCAVG_CNT_W-1:0] cnt_r; // samples taken so far
  logic [3:0] ofs_r; // scan input offset
  logic flag_r; // done flag
  adcavg_res_t res_r; // result register
  logic [ADCAVG_CNT_W-1:0] target; // samples to take
  logic trig; // accepted trigger
  logic last_smp; // this sample completes the set
  logic [ADCAVG_ACC_W-1:0] sum_nxt; // sum including this sample
  logic more_scan; // scan has further inputs
  logic free_seq_r; // running set was launched in free-run mode
  logic stop_free; // free-run bit dropped during its own set

  // sample count from log field, capped
  function automatic logic [ADCAVG_CNT_W-1:0] n_of(
      input logic [ADCAVG_LOG_W-1:0] lg);
    logic [ADCAVG_LOG_W-1:0] l;
    l = (lg > ADCAVG_LOG_W'(ADCAVG_MAX_LOG)) ?
        ADCAVG_LOG_W'(ADCAVG_MAX_LOG) : lg;
    n_of = ADCAVG_CNT_W'(1) << l;
  endfunction

  // extend a raw sample into accumulator width, sign-filled only in signed mode
  function automatic logic [ADCAVG_ACC_W-1:0] ext(
      input logic [ADCAVG_RES_W-1:0] d, input logic sgn);
    ext = sgn ? {{(ADCAVG_ACC_W-ADCAVG_RES_W){d[ADCAVG_RES_W-1]}}, d}
              : {{(ADCAVG_ACC_W-ADCAVG_RES_W){1'b0}}, d};
  endfunction

  // divide by count; unsigned mode shifts in zeros, never sign bits
  function automatic logic [ADCAVG_ACC_W-1:0] shr(
      input logic [ADCAVG_ACC_W-1:0] a, input logic [ADCAVG_LOG_W-1:0] lg,
      input logic sgn);
    logic [ADCAVG_LOG_W-1:0] l;
    l = (lg > ADCAVG_LOG_W'(ADCAVG_MAX_LOG)) ?
        ADCAVG_LOG_W'(ADCAVG_MAX_LOG) : lg;
    shr = sgn ? ADCAVG_ACC_W'($signed(a) >>> l) : a >> l;
  endfunction

  assign target = n_of(CFG_I.avg_log);
  // one trigger of either kind launches a whole sequence
  assign trig = CFG_I.enable & (START_I | (EVENT_SEL_I & EVENT_I) |
                CFG_I.free_run);
  assign last_smp = (cnt_r + ADCAVG_CNT_W'(1)) == target;
  assign sum_nxt = acc_r + ext(CONV_DATA_I, CFG_I.signed_mode);
  assign more_scan = CFG_I.scan_en & (ofs_r != CFG_I.scan_last);
  // only a set that free-run launched is cut short by its bit dropping
  assign stop_free = free_seq_r & ~CFG_I.free_run &
                     (state_r != ADCAVG_IDLE);

  // ********************************************************************
  // sequencer
  // ********************************************************************
  // idle -> conv (issue start) -> wait (sample) -> conv again or done
  always_ff @(posedge CLOCK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      state_r <= ADCAVG_IDLE;
    end else if (!CFG_I.enable) begin
      state_r <= ADCAVG_IDLE; // disable forces idle; sum, result and flag are not cleared
    end else if (stop_free) begin
      // abandon the set at once; partial sums stay in the accumulator
      state_r <= ADCAVG_IDLE;
    end else begin
      unique case (state_r)
        ADCAVG_IDLE: begin
          if (trig) begin
            state_r <= ADCAVG_CONV;
          end
        end
        ADCAVG_CONV: begin
          state_r <= ADCAVG_WAIT; // next conversion needs no trigger
        end
        ADCAVG_WAIT: begin
          if (CONV_VALID_I) begin
            // stay on this input until all N samples are in
            state_r <= (last_smp && !more_scan) ? ADCAVG_DONE
                                                 : ADCAVG_CONV;
          end
        end
        ADCAVG_DONE: begin
          state_r <= ADCAVG_IDLE;
        end
      endcase
    end
  end

  // remember whether free-run launched the set now running
  always_ff @(posedge CLOCK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      free_seq_r <= 1'b0;
    end else if ((state_r == ADCAVG_IDLE) && trig) begin
      free_seq_r <= CFG_I.free_run;
    end
  end

  // accumulator and count; cleared at start of each set
  // stopping free-run mid-set may leave partial sums here until restart
  always_ff @(posedge CLOCK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      acc_r <= ADCAVG_ACC_RST;
      cnt_r <= ADCAVG_CNT_RST;
    end else if ((state_r == ADCAVG_IDLE) && trig) begin
      acc_r <= ADCAVG_ACC_RST;
      cnt_r <= ADCAVG_CNT_RST;
    end else if ((state_r == ADCAVG_WAIT) && CONV_VALID_I) begin
      acc_r <= last_smp ? ADCAVG_ACC_RST : sum_nxt;
      cnt_r <= last_smp ? ADCAVG_CNT_RST : cnt_r + ADCAVG_CNT_W'(1);
    end
  end

  // scan offset moves only once an input's averaging is complete
  always_ff @(posedge CLOCK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      ofs_r <= ADCAVG_INP_RST;
    end else if (!CFG_I.enable || ((state_r == ADCAVG_IDLE) && trig)) begin
      ofs_r <= ADCAVG_INP_RST;
    end else if ((state_r == ADCAVG_WAIT) && CONV_VALID_I && last_smp &&
                 more_scan) begin
      ofs_r <= ofs_r + 4'h1;
    end
  end

  // result latched at each completed average
  always_ff @(posedge CLOCK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      res_r <= '0;
    end else if ((state_r == ADCAVG_WAIT) && CONV_VALID_I && last_smp) begin
      res_r.value <= CFG_I.right_shift ?
          shr(sum_nxt, CFG_I.avg_log, CFG_I.signed_mode) : sum_nxt;
      res_r.input_ofs <= ofs_r;
    end
  end

  // done flag; a new completion wins over a clear in the same cycle
  always_ff @(posedge CLOCK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      flag_r <= 1'b0;
    end else if (state_r == ADCAVG_DONE) begin
      flag_r <= 1'b1;
    end else if (FLAG_CLR_I) begin
      flag_r <= 1'b0;
    end
  end

  // ********************************************************************
  // outputs
  // ********************************************************************
  // one start pulse per conversion; later pulses need no trigger
  assign CONV_START_O = (state_r == ADCAVG_CONV);
  assign START_BUSY_O = (state_r != ADCAVG_IDLE);
  assign INPUT_OFS_O = ofs_r;
  assign RESULT_O = res_r;
  assign DONE_FLAG_O = flag_r;

  // ********************************************************************
  // checks
  // ********************************************************************
  sequence conv_then_valid_s;
    CONV_START_O ##1 (state_r == ADCAVG_WAIT);
  endsequence

  single_trigger_a: assert property (
    @(posedge CLOCK_I) disable iff (!RST_B_I)
    ($rose(START_BUSY_O) && CFG_I.enable && !stop_free) |->
    conv_then_valid_s)
    else $error("trigger did not start a conversion");

  done_flag_a: assert property (
    @(posedge CLOCK_I) disable iff (!RST_B_I)
    (state_r == ADCAVG_DONE) |=> DONE_FLAG_O)
    else $error("done flag not set after last sample");

  scan_hold_a: assert property (
    @(posedge CLOCK_I) disable iff (!RST_B_I)
    (CFG_I.enable && !(CONV_VALID_I && last_smp) && state_r != ADCAVG_IDLE)
    |=> $stable(INPUT_OFS_O))
    else $error("scan offset moved mid-average");

  event_start_a: assert property (
    @(posedge CLOCK_I) disable iff (!RST_B_I)
    (state_r == ADCAVG_IDLE && CFG_I.enable && EVENT_SEL_I && EVENT_I)
    |=> CONV_START_O)
    else $error("event did not launch sequence");

  unsigned_zero_a: assert property (
    @(posedge CLOCK_I) disable iff (!RST_B_I)
    (state_r == ADCAVG_WAIT && CONV_VALID_I && last_smp &&
     CFG_I.right_shift && !CFG_I.signed_mode && CFG_I.avg_log != 4'h0)
    |=> !RESULT_O.value[ADCAVG_ACC_W-1])
    else $error("unsigned result sign-extended");

  free_stop_a: assert property (
    @(posedge CLOCK_I) disable iff (!RST_B_I)
    (START_BUSY_O && free_seq_r && !CFG_I.free_run) |=> !START_BUSY_O)
    else $error("free-run set kept running after stop");

  disable_stop_a: assert property (
    @(posedge CLOCK_I) disable iff (!RST_B_I)
    !CFG_I.enable |=> !START_BUSY_O)
    else $error("sequence kept running while disabled");

  clear_seq_a: assert property (
    @(posedge CLOCK_I) disable iff (!RST_B_I)
    (state_r == ADCAVG_IDLE && trig) |=> (acc_r == '0 && cnt_r == '0))
    else $error("accumulator not cleared at start");

  count_bound_a: assert property (
    @(posedge CLOCK_I) disable iff (!RST_B_I)
    cnt_r < target || !$stable(CFG_I.avg_log) || state_r == ADCAVG_IDLE)
    else $error("sample count ran past target");

endmodule

`default_nettype wire
